// [hw/gpc_pkg.sv]
// Purpose: Shared constants for the status pin control block.
// Assumes: MCLK is the crystal clock of the device.
// Notes:   Select codes, register offsets and reset values live here.
`default_nettype none

package gpc_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int        MCLK_HZ       = 10_000_000;
  localparam int        DIV_RATIO     = 192;
  localparam int        DIV_HALF      = DIV_RATIO / 2;

  // ----------------------------------------------------------------------
  // Signal select codes
  // ----------------------------------------------------------------------
  localparam logic [5:0] SEL_FIFO_THR  = 6'h02;
  localparam logic [5:0] SEL_FIFO_FULL = 6'h03;
  localparam logic [5:0] SEL_UNDERFLOW = 6'h05;
  localparam logic [5:0] SEL_SYNC_SENT = 6'h06;
  localparam logic [5:0] SEL_LOCK      = 6'h0a;
  localparam logic [5:0] SEL_SER_CLK   = 6'h0b;
  localparam logic [5:0] SEL_SER_SYNC  = 6'h0c;
  localparam logic [5:0] SEL_SER_ASYNC = 6'h0d;
  localparam logic [5:0] SEL_PA_PD     = 6'h1b;
  localparam logic [5:0] SEL_CHIP_RDY  = 6'h29;
  localparam logic [5:0] SEL_HIZ       = 6'h2e;
  localparam logic [5:0] SEL_CLK_DIV   = 6'h3f;
  localparam logic [5:0] SLEEP_LIMIT   = 6'h20;

  // ----------------------------------------------------------------------
  // Transmit buffer figures
  // ----------------------------------------------------------------------
  localparam logic [6:0] FIFO_DEPTH    = 7'h40;
  localparam logic [6:0] THR_BASE      = 7'h3d;

  // ----------------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFS_PIN_A_CFG = 5'h00;
  localparam logic [4:0] OFS_PIN_B_CFG = 5'h04;
  localparam logic [4:0] OFS_PIN_C_CFG = 5'h08;
  localparam logic [4:0] OFS_FIFO_THR  = 5'h0c;
  localparam logic [4:0] OFS_IRQ_STAT  = 5'h10;
  localparam logic [4:0] OFS_IRQ_MASK  = 5'h14;
  localparam logic [4:0] OFS_PIN_STATE = 5'h18;

  // Config field layout: select in [5:0], invert in bit 6.
  localparam int         CFG_INV_BIT   = 6;

  // Reset values.
  localparam logic [6:0] RST_PIN_A_CFG = {1'b0, SEL_CLK_DIV};
  localparam logic [6:0] RST_PIN_B_CFG = {1'b0, SEL_HIZ};
  localparam logic [6:0] RST_PIN_C_CFG = {1'b0, SEL_CHIP_RDY};
  localparam logic [3:0] RST_FIFO_THR  = 4'h0;
  localparam logic [2:0] RST_IRQ_MASK  = 3'h0;

  // Interrupt status bit positions.
  localparam int         EV_THR        = 0;
  localparam int         EV_UNDERFLOW  = 1;
  localparam int         EV_LOCK       = 2;

  typedef enum logic {BUS_IDLE, BUS_ANSWER} gpc_bus_type;

endpackage : gpc_pkg

`default_nettype wire

// [hw/gpc_clk_div.sv]
// Purpose: Square wave at the input clock divided by an even ratio.
// Assumes: HALF is at least 1.
// Notes:   Runs from reset so the host can be clocked at power-on.
`default_nettype none

module gpc_clk_div #(
  parameter int HALF = 96
) (
  input  wire logic clk,      // Crystal clock.
  input  wire logic rst,      // Asynchronous reset, high.
  output logic      clk_out   // Divided clock.
);

  logic [7:0] cnt;

  // ----------------------------------------------------------------------
  // Half period counter
  // ----------------------------------------------------------------------
  // R04 divide by ratio
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt     <= 8'h00;
      clk_out <= 1'b0;
    end else if (cnt == 8'(HALF - 1)) begin
      cnt     <= 8'h00;
      clk_out <= ~clk_out;
    end else begin
      cnt     <= cnt + 8'h01;
    end
  end

  a_div_toggle: assert property ( // R04
    @(posedge clk) disable iff (rst)
    (cnt == 8'(HALF - 1)) |=> (clk_out != $past(clk_out))
  ) else $error("divided clock missed its toggle");

  a_div_steady: assert property ( // R04
    @(posedge clk) disable iff (rst)
    (cnt != 8'(HALF - 1)) |=> (clk_out == $past(clk_out))
  ) else $error("divided clock toggled early");

endmodule : gpc_clk_div

`default_nettype wire

// [hw/gpc_pin_mux.sv]
// Purpose: Picks one internal signal for a status pin, with polarity.
// Assumes: Reserved select codes read zero in the source vector.
// Notes:   Pure logic; the top registers the result.
`default_nettype none

module gpc_pin_mux
  import gpc_pkg::*;
#(
  parameter bit FORCE_FLIP = 1'b0,
  parameter bit HIZ_OK     = 1'b0
) (
  input  wire logic [5:0]  sel,    // Signal select.
  input  wire logic        inv,    // Polarity invert.
  input  wire logic        hold,   // Sleep levels in force.
  input  wire logic [63:0] src,    // Internal signals by code.
  output logic             level,  // Pin level.
  output logic             drive   // Pin driven when high.
);

  // ----------------------------------------------------------------------
  // Selection, invert, sleep forcing
  // ----------------------------------------------------------------------
  always_comb begin
    drive = 1'b1;
    // R14 invert when awake
    level = src[sel] ^ inv;
    // R06 R08 forced below limit
    if (hold && (sel < SLEEP_LIMIT)) begin
      level = inv ^ FORCE_FLIP;
    end
    // R09 high impedance code
    if (HIZ_OK && (sel == SEL_HIZ)) begin
      drive = 1'b0;
    end
  end

endmodule : gpc_pin_mux

`default_nettype wire

// [hw/gpc_top.sv]
// Purpose: Status pin control: three output pins, each showing a chosen
//          internal signal, set up over an Avalon-MM slave.
// Assumes: All inputs are synchronous to MCLK; MCLK is the crystal.
// Notes:   One wait state on every bus access.
//
// Behaviour
// R01 - Each of three pins shows the signal chosen by its own select field.
// R02 - Pin b shares the serial out pad; status only while deselected.
// R03 - After reset pin b is high impedance.
// R04 - After reset pin a carries the crystal clock divided by 192.
// R05 - The host may later replace pin a's clock by writing its select field.
// R06 - Sleep with code below 0x20 forces a, c to invert, b to its inverse.
// R07 - The sleep levels hold until chip ready low goes low.
// R08 - For select 0x20 or above a pin keeps its programmed signal in sleep.
// R09 - Pin b with select 0x2e is high impedance in every state; the code still drives serial data on it while selected.
// R10 - Code 0x02 is high while the buffer fill is at or above the threshold.
// R11 - Code 0x03 rises on a full buffer and falls once below threshold.
// R12 - Code 0x05 rises on buffer underflow and falls on a flush.
// R13 - Code 0x0a shows the synthesizer lock detector.
// R14 - Outside sleep an invert bit of one complements the pin's signal.
// R15 - Reserved codes drive a fixed inactive level.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`default_nettype none

module gpc_top
  import gpc_pkg::*;
(
  input  wire logic        MCLK,              // Crystal clock.
  input  wire logic        RST,               // Asynchronous reset, high.
  input  wire logic [4:0]  AVS_ADDRESS,       // Byte address.
  input  wire logic        AVS_READ,          // Read request.
  input  wire logic        AVS_WRITE,         // Write request.
  input  wire logic [31:0] AVS_WRITEDATA,     // Write data.
  input  wire logic [3:0]  AVS_BYTEENABLE,    // Byte lanes.
  output logic      [31:0] AVS_READDATA,      // Read data.
  output logic             AVS_WAITREQUEST,   // Slave stall.
  output logic             IRQ,               // Interrupt level.
  input  wire logic [6:0]  TX_LEVEL,          // Bytes in buffer.
  input  wire logic        TX_UNDERFLOW,      // Underflow pulse.
  input  wire logic        TX_FLUSH,          // Flush pulse.
  input  wire logic        SYNC_SENT,         // Sync sent to packet end.
  input  wire logic        PLL_LOCK,          // Lock detector.
  input  wire logic        SER_CLK,           // Serial clock.
  input  wire logic        SER_SYNC_DATA,     // Synchronous data.
  input  wire logic        SER_ASYNC_DATA,    // Asynchronous data.
  input  wire logic        PA_PD,             // Power amp down.
  input  wire logic        CHIP_READY_LOW,    // Chip ready, low.
  input  wire logic        SLEEP,             // Sleep state.
  input  wire logic        CHIP_SELECT_LOW,   // Serial select, low.
  input  wire logic        SPI_SO,            // Serial data out.
  output logic             STATUS_PIN_A,      // Pin a level.
  output logic             STATUS_PIN_B,      // Pin b level.
  output logic             STATUS_PIN_B_OE_N, // Pin b enable, low.
  output logic             STATUS_PIN_C       // Pin c level.
);

  import gpc_pkg::*;

  logic [6:0]   cfg_a, cfg_b, cfg_c;
  logic [3:0]   fifo_thr;
  logic [2:0]   irq_stat, irq_mask, next_stat, ev;
  gpc_bus_type  bus_state;
  logic         accept;
  logic         wr_en;
  logic [31:0]  rd_mux;
  logic [6:0]   thr_bytes;
  logic         next_thr;
  logic         thr_flag, full_flag, uf_flag;
  logic         lock_prev;
  logic         hold;
  logic         div_clk;
  logic [63:0]  src;
  logic         lvl_a, lvl_b, lvl_c;
  logic         drv_b;

  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------------
  // Waitrequest idles high; a request is answered one edge later, which
  // costs a cycle but keeps every bus output straight from a flip-flop.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      bus_state       <= BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_state       <= BUS_ANSWER;
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= AVS_READ ? rd_mux : 32'h0000_0000;
          end
        end
        BUS_ANSWER: begin
          bus_state       <= BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
        default: begin
          bus_state       <= BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  assign accept = (bus_state == BUS_ANSWER) && (AVS_READ || AVS_WRITE);
  assign wr_en  = accept && AVS_WRITE && AVS_BYTEENABLE[0];

  // Read decode; unmapped addresses read zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS)
      OFS_PIN_A_CFG: rd_mux = {25'h0, cfg_a};
      OFS_PIN_B_CFG: rd_mux = {25'h0, cfg_b};
      OFS_PIN_C_CFG: rd_mux = {25'h0, cfg_c};
      OFS_FIFO_THR:  rd_mux = {28'h0, fifo_thr};
      OFS_IRQ_STAT:  rd_mux = {29'h0, irq_stat};
      OFS_IRQ_MASK:  rd_mux = {29'h0, irq_mask};
      OFS_PIN_STATE: rd_mux = {27'h0, hold, STATUS_PIN_B_OE_N,
                               STATUS_PIN_C, STATUS_PIN_B, STATUS_PIN_A};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // R03 reset defaults
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cfg_a    <= RST_PIN_A_CFG;
      cfg_b    <= RST_PIN_B_CFG;
      cfg_c    <= RST_PIN_C_CFG;
      fifo_thr <= RST_FIFO_THR;
      irq_mask <= RST_IRQ_MASK;
    end else if (wr_en) begin
      case (AVS_ADDRESS)
        OFS_PIN_A_CFG: cfg_a    <= AVS_WRITEDATA[6:0];
        OFS_PIN_B_CFG: cfg_b    <= AVS_WRITEDATA[6:0];
        OFS_PIN_C_CFG: cfg_c    <= AVS_WRITEDATA[6:0];
        OFS_FIFO_THR:  fifo_thr <= AVS_WRITEDATA[3:0];
        OFS_IRQ_MASK:  irq_mask <= AVS_WRITEDATA[2:0];
        default:       ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Transmit buffer flags
  // ----------------------------------------------------------------------
  // Each threshold step is four bytes below the previous one.
  assign thr_bytes = THR_BASE - {1'b0, fifo_thr, 2'b00};
  // R10 threshold compare
  assign next_thr  = (TX_LEVEL >= thr_bytes);

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      thr_flag  <= 1'b0;
      full_flag <= 1'b0;
      uf_flag   <= 1'b0;
      lock_prev <= 1'b0;
    end else begin
      thr_flag  <= next_thr;
      lock_prev <= PLL_LOCK;
      // R11 full until below threshold
      if (TX_LEVEL >= FIFO_DEPTH) begin
        full_flag <= 1'b1;
      end else if (!next_thr) begin
        full_flag <= 1'b0;
      end
      // R12 underflow until flush
      if (TX_UNDERFLOW) begin
        uf_flag <= 1'b1;
      end else if (TX_FLUSH) begin
        uf_flag <= 1'b0;
      end
    end
  end

  a_thr_flag: assert property ( // R10
    1'b1 |=> (thr_flag == $past(TX_LEVEL >= thr_bytes))
  ) else $error("threshold flag does not follow fill level");
  a_full_hold: assert property ( // R11
    (TX_LEVEL == FIFO_DEPTH) |=> full_flag
  ) else $error("full flag not set on full buffer");
  a_uflow_set: assert property ( // R12
    (TX_UNDERFLOW ##1 (!TX_FLUSH && !TX_UNDERFLOW)) |=> uf_flag
  ) else $error("underflow flag lost before flush");

  // ----------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------
  assign ev[EV_THR]       = next_thr && !thr_flag;
  assign ev[EV_UNDERFLOW] = TX_UNDERFLOW && !uf_flag;
  assign ev[EV_LOCK]      = PLL_LOCK && !lock_prev;

  // A new event wins over a write-one clear in the same cycle.
  always_comb begin
    next_stat = irq_stat;
    if (wr_en && (AVS_ADDRESS == OFS_IRQ_STAT)) begin
      next_stat = irq_stat & ~AVS_WRITEDATA[2:0];
    end
    next_stat = next_stat | ev;
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      irq_stat <= 3'h0;
      IRQ      <= 1'b0;
    end else begin
      irq_stat <= next_stat;
      IRQ      <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Sleep hold
  // ----------------------------------------------------------------------
  // R07 hold until ready
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      hold <= 1'b0;
    end else if (SLEEP) begin
      hold <= 1'b1;
    end else if (!CHIP_READY_LOW) begin
      hold <= 1'b0;
    end
  end

  a_hold_release: assert property ( // R07
    (!SLEEP && !CHIP_READY_LOW) |=> !hold
  ) else $error("sleep levels held past chip ready");

  // ----------------------------------------------------------------------
  // Signal sources
  // ----------------------------------------------------------------------
  // R04 default clock source
  gpc_clk_div #(.HALF(DIV_HALF)) u_div (
    .clk(MCLK), .rst(RST), .clk_out(div_clk));

  // R15 reserved codes read zero
  always_comb begin
    src                = 64'h0;
    src[SEL_FIFO_THR]  = thr_flag;
    src[SEL_FIFO_FULL] = full_flag;
    src[SEL_UNDERFLOW] = uf_flag;
    src[SEL_SYNC_SENT] = SYNC_SENT;
    // R13 lock detector
    src[SEL_LOCK]      = PLL_LOCK;
    src[SEL_SER_CLK]   = SER_CLK;
    src[SEL_SER_SYNC]  = SER_SYNC_DATA;
    src[SEL_SER_ASYNC] = SER_ASYNC_DATA;
    src[SEL_PA_PD]     = PA_PD;
    src[SEL_CHIP_RDY]  = CHIP_READY_LOW;
    src[SEL_CLK_DIV]   = div_clk;
  end

  // ----------------------------------------------------------------------
  // Pin selection
  // ----------------------------------------------------------------------
  // R01 one select per pin
  gpc_pin_mux #(.FORCE_FLIP(1'b0), .HIZ_OK(1'b0)) u_mux_a (
    .sel(cfg_a[5:0]), .inv(cfg_a[CFG_INV_BIT]), .hold(hold), .src(src),
    .level(lvl_a), .drive());

  // R06 pin b complement
  gpc_pin_mux #(.FORCE_FLIP(1'b1), .HIZ_OK(1'b1)) u_mux_b (
    .sel(cfg_b[5:0]), .inv(cfg_b[CFG_INV_BIT]), .hold(hold), .src(src),
    .level(lvl_b), .drive(drv_b));

  gpc_pin_mux #(.FORCE_FLIP(1'b0), .HIZ_OK(1'b0)) u_mux_c (
    .sel(cfg_c[5:0]), .inv(cfg_c[CFG_INV_BIT]), .hold(hold), .src(src),
    .level(lvl_c), .drive());

  // ----------------------------------------------------------------------
  // Pin registers
  // ----------------------------------------------------------------------
  // Pin b starts released so a shared serial bus is not disturbed.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      STATUS_PIN_A      <= 1'b0;
      STATUS_PIN_B      <= 1'b0;
      STATUS_PIN_B_OE_N <= 1'b1;
      STATUS_PIN_C      <= 1'b0;
    end else begin
      STATUS_PIN_A <= lvl_a;
      STATUS_PIN_C <= lvl_c;
      // R02 serial data while selected
      if (!CHIP_SELECT_LOW) begin
        STATUS_PIN_B      <= SPI_SO;
        STATUS_PIN_B_OE_N <= 1'b0;
      end else begin
        STATUS_PIN_B      <= lvl_b;
        STATUS_PIN_B_OE_N <= ~drv_b;
      end
    end
  end

  a_spi_share: assert property ( // R02
    !CHIP_SELECT_LOW |=> (!STATUS_PIN_B_OE_N && STATUS_PIN_B == $past(SPI_SO))
  ) else $error("pin b does not carry serial data when selected");
  a_pin_b_hiz: assert property ( // R09
    (CHIP_SELECT_LOW && cfg_b[5:0] == SEL_HIZ) |=> STATUS_PIN_B_OE_N
  ) else $error("pin b driven with high impedance code");
  a_sleep_force_a: assert property ( // R06
    (hold && cfg_a[5:0] < SLEEP_LIMIT)
      |=> (STATUS_PIN_A == $past(cfg_a[CFG_INV_BIT]))
  ) else $error("pin a not at forced sleep level");
  a_sleep_force_b: assert property ( // R06
    (hold && CHIP_SELECT_LOW && cfg_b[5:0] < SLEEP_LIMIT)
      |=> (STATUS_PIN_B == !$past(cfg_b[CFG_INV_BIT]))
  ) else $error("pin b not at complement sleep level");
  a_sleep_live_c: assert property ( // R08
    (hold && cfg_c[5:0] >= SLEEP_LIMIT)
      |=> (STATUS_PIN_C == $past(src[cfg_c[5:0]] ^ cfg_c[CFG_INV_BIT]))
  ) else $error("pin c not live in sleep for high code");
  a_lock_out: assert property ( // R13
    (!hold && cfg_a[5:0] == SEL_LOCK)
      |=> (STATUS_PIN_A == $past(PLL_LOCK ^ cfg_a[CFG_INV_BIT]))
  ) else $error("pin a does not show lock detector");
  a_invert_a: assert property ( // R14
    (!hold && cfg_a[CFG_INV_BIT])
      |=> (STATUS_PIN_A == !$past(src[cfg_a[5:0]]))
  ) else $error("pin a not inverted");
  a_clk_out_a: assert property ( // R04
    (!hold && cfg_a == RST_PIN_A_CFG) |=> (STATUS_PIN_A == $past(div_clk))
  ) else $error("pin a does not carry divided clock");

endmodule : gpc_top

`default_nettype wire

// [test/gpc_host_model.sv]
// Purpose: Host side model that samples status pins a and b.
// Assumes: The host samples on MCLK and sees pin b only when deselected.
// Notes:   A released pin b wire shows a pattern that flips every cycle.
`default_nettype none

module gpc_host_model (
  input  wire logic        mclk,            // Crystal clock.
  input  wire logic        rst,             // Asynchronous reset, high.
  input  wire logic        pin_a,           // Pin a level.
  input  wire logic        pin_b,           // Pin b level.
  input  wire logic        pin_b_oe_n,      // Pin b enable, low.
  input  wire logic        chip_select_low, // Serial select, low.
  output logic      [15:0] a_period,        // Cycles between pin a rises.
  output logic             b_seen           // Last sampled pin b.
);
  timeunit 1ns;
  timeprecision 1ns;

  logic        last_b;  // Last value on the pin b wire.
  logic        b_wire;  // Resolved pin b wire.
  logic        a_prev;  // Pin a one cycle back.
  logic [15:0] cnt;     // Cycles since the last pin a rise.

  // No pull on the wire, so a released pad must not keep its old level.
  assign b_wire = pin_b_oe_n ? ~last_b : pin_b;

  // Wire history for the floating pattern.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      last_b <= 1'b0;
    end else begin
      last_b <= b_wire;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      b_seen <= 1'b0;
    end else if (chip_select_low) begin
      b_seen <= b_wire;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      a_prev   <= 1'b0;
      cnt      <= 16'h0;
      a_period <= 16'h0;
    end else begin
      a_prev <= pin_a;
      if (pin_a && !a_prev) begin
        a_period <= cnt + 16'h1;
        cnt      <= 16'h0;
      end else begin
        cnt <= cnt + 16'h1;
      end
    end
  end
endmodule : gpc_host_model

`default_nettype wire

// [test/general_output_pin_control_bench.sv]
// Purpose: Self-checking bench for the status pin control block.
// Assumes: One wait state bus; pins settle within four cycles.
// Notes:   Expectations come from the select codes and register layout.
`default_nettype none

module general_output_pin_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import gpc_pkg::*;

  logic MCLK = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [4:0] AVS_ADDRESS = 5'h00;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [6:0] TX_LEVEL = 7'h00;
  logic TX_UNDERFLOW = 1'b0, TX_FLUSH = 1'b0, PLL_LOCK = 1'b0;
  logic SER_ASYNC_DATA = 1'b0, SER_SYNC_DATA = 1'b0, SLEEP = 1'b0;
  logic side_in = 1'b0;  // Spare sources for the less used codes.
  logic CHIP_READY_LOW = 1'b1, CHIP_SELECT_LOW = 1'b1, SPI_SO = 1'b0;
  logic AVS_WAITREQUEST, IRQ, PIN_A, PIN_B, PIN_B_OE_N, PIN_C, b_seen;
  logic [15:0] a_period;
  int failures = 0, checks_done = 0;

  // ----------------------------------------------------------------------
  // Clock, design and host
  // ----------------------------------------------------------------------
  initial begin
    forever #50 MCLK = ~MCLK;
  end

  gpc_top dut (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .IRQ(IRQ), .TX_LEVEL(TX_LEVEL), .TX_UNDERFLOW(TX_UNDERFLOW),
    .TX_FLUSH(TX_FLUSH), .SYNC_SENT(side_in), .PLL_LOCK(PLL_LOCK),
    .SER_CLK(side_in), .SER_SYNC_DATA(SER_SYNC_DATA),
    .SER_ASYNC_DATA(SER_ASYNC_DATA), .PA_PD(side_in),
    .CHIP_READY_LOW(CHIP_READY_LOW), .SLEEP(SLEEP),
    .CHIP_SELECT_LOW(CHIP_SELECT_LOW), .SPI_SO(SPI_SO),
    .STATUS_PIN_A(PIN_A), .STATUS_PIN_B(PIN_B),
    .STATUS_PIN_B_OE_N(PIN_B_OE_N), .STATUS_PIN_C(PIN_C));

  gpc_host_model host (.mclk(MCLK), .rst(RST), .pin_a(PIN_A),
    .pin_b(PIN_B), .pin_b_oe_n(PIN_B_OE_N),
    .chip_select_low(CHIP_SELECT_LOW), .a_period(a_period),
    .b_seen(b_seen));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask : tick

  // One bus access; the request holds until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge MCLK);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE     <= wr;
    AVS_READ      <= !wr;
    do begin
      @(posedge MCLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    if (n >= 50) begin
      failures++;
      stop_test();
    end
    q = AVS_READDATA;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    tick(4);
  endtask : wr

  // Sets the buffer level and looks at pin c.
  task automatic level(input logic [6:0] lv, input logic exp);
    TX_LEVEL <= lv;
    tick(4);
    check(32'(PIN_C), 32'(exp));
  endtask : level

  // A hang anywhere counts as a mismatch.
  initial begin
    tick(20000);
    failures++;
    stop_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    tick(5);
    RST <= 1'b0;
    tick(1);
    check(32'(PIN_B_OE_N), 32'h1);
    bus(1'b0, OFS_PIN_A_CFG, 32'h0, rd);
    check(rd, 32'(RST_PIN_A_CFG));
    bus(1'b0, OFS_PIN_B_CFG, 32'h0, rd);
    check(rd, 32'(RST_PIN_B_CFG));
    check(32'(PIN_B_OE_N), 32'h1);
    bus(1'b0, 5'h1c, 32'h0, rd);
    check(rd, 32'h0);
    tick(400);
    check(32'(a_period), DIV_RATIO);
    // Masked event, then unmasked, then cleared.
    wr(OFS_IRQ_STAT, 32'h7);
    PLL_LOCK <= 1'b1;
    tick(4);
    check(32'(IRQ), 32'h0);
    wr(OFS_IRQ_MASK, 32'h4);
    check(32'(IRQ), 32'h1);
    bus(1'b0, OFS_IRQ_STAT, 32'h0, rd);
    check(rd, 32'h4);
    wr(OFS_IRQ_STAT, 32'h4);
    check(32'(IRQ), 32'h0);
    // Separate selects, lock output and polarity.
    SER_ASYNC_DATA <= 1'b1;
    wr(OFS_PIN_A_CFG, 32'(SEL_LOCK));
    wr(OFS_PIN_C_CFG, 32'(SEL_SER_ASYNC));
    check(32'(PIN_A), 32'h1);
    check(32'(PIN_C), 32'h1);
    wr(OFS_PIN_A_CFG, 32'h40 | 32'(SEL_LOCK));
    check(32'(PIN_A), 32'h0);
    // Threshold code 13 gives 9 bytes.
    wr(OFS_FIFO_THR, 32'hd);
    wr(OFS_PIN_C_CFG, 32'(SEL_FIFO_THR));
    level(7'd8, 1'b0);
    level(7'd9, 1'b1);
    wr(OFS_PIN_C_CFG, 32'(SEL_FIFO_FULL));
    level(7'd63, 1'b0);
    level(7'd64, 1'b1);
    level(7'd9, 1'b1);
    level(7'd8, 1'b0);
    wr(OFS_PIN_C_CFG, 32'(SEL_UNDERFLOW));
    TX_UNDERFLOW <= 1'b1;
    tick(1);
    TX_UNDERFLOW <= 1'b0;
    level(7'd0, 1'b1);
    TX_FLUSH <= 1'b1;
    tick(1);
    TX_FLUSH <= 1'b0;
    level(7'd0, 1'b0);
    // Remaining live codes on pin c, then a reserved code reads low.
    side_in <= 1'b1;
    wr(OFS_PIN_C_CFG, 32'(SEL_SYNC_SENT));
    check(32'(PIN_C), 32'h1);
    wr(OFS_PIN_C_CFG, 32'(SEL_SER_CLK));
    check(32'(PIN_C), 32'h1);
    wr(OFS_PIN_C_CFG, 32'(SEL_PA_PD));
    check(32'(PIN_C), 32'h1);
    wr(OFS_PIN_C_CFG, 32'h0);
    check(32'(PIN_C), 32'h0);
    // Sleep: a and b forced, c keeps a high code.
    wr(OFS_PIN_B_CFG, 32'(SEL_SER_SYNC));
    wr(OFS_PIN_C_CFG, 32'(SEL_CHIP_RDY));
    SLEEP <= 1'b1;
    tick(4);
    check(32'(PIN_A), 32'h1);
    check(32'(b_seen), 32'h1);
    check(32'(PIN_C), 32'h1);
    SLEEP <= 1'b0;
    tick(4);
    check(32'(PIN_A), 32'h1);
    CHIP_READY_LOW <= 1'b0;
    tick(4);
    check(32'(PIN_A), 32'h0);
    check(32'(b_seen), 32'h0);
    check(32'(PIN_C), 32'h0);
    wr(OFS_PIN_B_CFG, 32'(SEL_HIZ));
    SLEEP <= 1'b1;
    tick(4);
    check(32'(PIN_B_OE_N), 32'h1);
    CHIP_SELECT_LOW <= 1'b0;
    SPI_SO          <= 1'b1;
    tick(4);
    check(32'(PIN_B_OE_N), 32'h0);
    check(32'(PIN_B), 32'h1);
    // Pin state word: a forced high, b from the serial line, c live low.
    bus(1'b0, OFS_PIN_STATE, 32'h0, rd);
    check(rd, 32'h13);
    stop_test();
  end
endmodule : general_output_pin_control_bench

`default_nettype wire
